/* src/ssp_pkg.sv */
// How it works
// - slave select low gates slave shifting; ignored outside slave mode.
// - in slave mode, control bit 0 reads back the select pin level.
// - done flag bit 7 sets per byte; cleared by write or data read.
// - collision bit 6 sets on data write during a transfer; write clears.
// - control bit 5 gives shared pins to serial port, else two-wire.
// - control bit 4 picks master with clock output, else slave input.
// - control bit 3 sets the serial clock idle level.
// - control bit 2 picks leading or trailing launch edge.
// - control bits 1 and 0 choose the master bit rate.
// - both ends should share idle level and phase settings.
// - master data write runs eight periods, latches byte, sets done.
// - slave data write preloads byte; each outside clock shifts one bit.
// - slave byte ends at eighth clock (phase 1) or select rise (phase 0).
// - software master drives data bit when enabled, clock bit directly.
// - with driver off, data input bit captures data pin on clock rise.
// - two-wire control bit 2 holds the slave in reset.
// - direction bit 1 set while transmitting, cleared while receiving.
// - byte flag bit 0 sets per slave byte; data access clears it.
// - own address register holds 7-bit address, resets to 55 hex.
// - serial bytes shift eight bits, most significant bit first.
// - after address match the slave holds clock low until flag clears.
package ssp_pkg;
   localparam int AW = 10;
   localparam logic [7:0] IDX_IIC_DATA = 8'h9a;
   localparam logic [7:0] IDX_IIC_ADDR = 8'h9b;
   localparam logic [7:0] IDX_IIC_CTL = 8'he8;
   localparam logic [7:0] IDX_SPI_DATA = 8'hf7;
   localparam logic [7:0] IDX_SPI_CTL = 8'hf8;
   localparam logic [7:0] RST_IIC_DATA = 8'h00;
   localparam logic [7:0] RST_IIC_ADDR = 8'h55;
   localparam logic [7:0] RST_IIC_CTL = 8'h00;
   localparam logic [7:0] RST_SPI_DATA = 8'h00;
   localparam logic [7:0] RST_SPI_CTL = 8'h00;
   localparam int B_DONE = 7, B_COLL = 6, B_PINS = 5, B_MASTER = 4;
   localparam int B_IDLE = 3, B_PHASE = 2, B_RATE_HI = 1, B_RATE_LO = 0;
   localparam int B_SW_DOUT = 7, B_SW_DEN = 6, B_SW_CLK = 5, B_SW_DIN = 4;
   localparam int B_IIC_MSEL = 3, B_IIC_SRST = 2, B_IIC_DIR = 1, B_IIC_FLAG = 0;
   localparam logic [7:0] IIC_CTL_WMASK = 8'hec;
   localparam logic [4:0] LAST_EDGE = 5'h0f;
   localparam logic [3:0] IIC_ACK_BIT = 4'h8;
   localparam logic [3:0] IIC_END_BIT = 4'h9;
   // half period of the master clock, in mclk cycles
   // fastest rate must outlast the miso synchroniser latency
   localparam logic [7:0] RATE_HALF0 = 8'h06;
   localparam logic [7:0] RATE_HALF1 = 8'h08;
   localparam logic [7:0] RATE_HALF2 = 8'h20;
   localparam logic [7:0] RATE_HALF3 = 8'h40;
   typedef enum logic [1:0] {SPI_IDLE = 2'b01, SPI_RUN = 2'b10} ssp_spi_e;
   typedef struct packed {
      logic [2:0] s_scl;
      logic [2:0] s_sda;
      logic [2:0] s_miso;
      logic [2:0] s_ss;
      logic f_scl;
      logic f_sda;
      logic f_miso;
      logic f_ss;
      logic waitreq;
      logic [7:0] rdata;
      logic [7:0] spi_ctl;
      logic [7:0] spi_dat;
      logic [7:0] sh;
      ssp_spi_e spi_st;
      logic [4:0] cnt;
      logic [7:0] hcnt;
      logic sclk_o;
      logic dout;
      logic [7:0] iic_ctl;
      logic [7:0] iic_dat;
      logic [7:0] iic_adr;
      logic [7:0] ish;
      logic [3:0] ibit;
      logic act;
      logic match;
      logic ackdrv;
      logic txbit;
      logic scl_out;
      logic scl_oe;
      logic sda_out;
      logic sda_oe;
      logic miso_out;
      logic miso_oe;
   } ssp_state_s;
   function automatic logic [AW-1:0] addr_of(input logic [7:0] idx);
      return {idx, 2'b00};
   endfunction
   function automatic logic [7:0] rate_half(input logic [1:0] sel);
      case (sel)
         2'h0: return RATE_HALF0;
         2'h1: return RATE_HALF1;
         2'h2: return RATE_HALF2;
         default: return RATE_HALF3;
      endcase
   endfunction
endpackage

/* src/ssp_top.sv */
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module ssp_top (
   input wire logic mclk, // core clock
   input wire logic reset, // sync reset
   input wire logic [ssp_pkg::AW-1:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic shared_serial_clock_in, // clock pin level
   output logic shared_serial_clock_out, // clock pin drive value
   output logic shared_serial_clock_oe, // clock pin drive enable
   input wire logic shared_serial_data_in, // data/mosi pin level
   output logic shared_serial_data_out, // data/mosi drive value
   output logic shared_serial_data_oe, // data/mosi drive enable
   input wire logic miso_in, // miso pin level
   output logic miso_out, // miso drive value
   output logic miso_oe, // miso drive enable
   input wire logic slave_select_n // slave select pin
);
   import ssp_pkg::*;

   ssp_state_s q;
   ssp_state_s n;
   logic req, rd_acc, wr_acc, spi_en, master, clock_idle_level, clock_edge_phase, busy;
   logic ev, lead, sample, ss_rise, scl_rise, scl_fall, sda_rise, sda_fall;
   logic iic_on, dir, fin;
   logic [7:0] wd;

   always_comb begin
      n = q;
      n.s_scl = {q.s_scl[1:0], shared_serial_clock_in};
      n.s_sda = {q.s_sda[1:0], shared_serial_data_in};
      n.s_miso = {q.s_miso[1:0], miso_in};
      n.s_ss = {q.s_ss[1:0], slave_select_n};
      if (q.s_scl[1] == q.s_scl[2]) n.f_scl = q.s_scl[2];
      if (q.s_sda[1] == q.s_sda[2]) n.f_sda = q.s_sda[2];
      if (q.s_miso[1] == q.s_miso[2]) n.f_miso = q.s_miso[2];
      if (q.s_ss[1] == q.s_ss[2]) n.f_ss = q.s_ss[2];
      scl_rise = n.f_scl & ~q.f_scl;
      scl_fall = ~n.f_scl & q.f_scl;
      sda_rise = n.f_sda & ~q.f_sda;
      sda_fall = ~n.f_sda & q.f_sda;
      ss_rise = n.f_ss & ~q.f_ss;
      spi_en = q.spi_ctl[B_PINS];
      master = q.spi_ctl[B_MASTER];
      clock_idle_level = q.spi_ctl[B_IDLE];
      clock_edge_phase = q.spi_ctl[B_PHASE];
      dir = q.iic_ctl[B_IIC_DIR];
      busy = (q.spi_st == SPI_RUN) | (~master & (q.cnt != 5'h00));
      wd = avs_writedata[7:0];
      req = avs_read | avs_write;
      rd_acc = avs_read & ~q.waitreq;
      wr_acc = avs_write & ~q.waitreq & avs_byteenable[0];
      ev = 1'b0;
      lead = 1'b0;
      sample = 1'b0;
      fin = 1'b0;

      // bus slave: one wait cycle, then accept
      n.waitreq = ~(req & q.waitreq);
      if (req & q.waitreq) begin
         if (avs_address == addr_of(IDX_IIC_DATA)) begin
            n.rdata = q.iic_dat;
         end else if (avs_address == addr_of(IDX_IIC_ADDR)) begin
            n.rdata = q.iic_adr;
         end else if (avs_address == addr_of(IDX_IIC_CTL)) begin
            n.rdata = q.iic_ctl;
         end else if (avs_address == addr_of(IDX_SPI_DATA)) begin
            n.rdata = q.spi_dat;
         end else if (avs_address == addr_of(IDX_SPI_CTL)) begin
            n.rdata = q.spi_ctl;
            if (~master) n.rdata[B_RATE_LO] = q.f_ss;
         end else begin
            n.rdata = 8'h00;
         end
      end

      // software side effects first, hardware sets afterwards
      if (wr_acc) begin
         if (avs_address == addr_of(IDX_IIC_DATA)) begin
            n.iic_dat = wd;
            if (q.match & dir) begin
               n.ish = wd;
               n.txbit = wd[7];
            end
         end else if (avs_address == addr_of(IDX_IIC_ADDR)) begin
            n.iic_adr = wd;
         end else if (avs_address == addr_of(IDX_IIC_CTL)) begin
            n.iic_ctl = (q.iic_ctl & ~IIC_CTL_WMASK) | (wd & IIC_CTL_WMASK);
         end else if (avs_address == addr_of(IDX_SPI_CTL)) begin
            n.spi_ctl = wd;
         end else if (avs_address == addr_of(IDX_SPI_DATA)) begin
            if (busy) begin
               n.spi_ctl[B_COLL] = 1'b1;
            end else begin
               n.sh = wd;
               n.dout = wd[7];
               if (master & spi_en) begin
                  n.spi_st = SPI_RUN;
                  n.hcnt = 8'h00;
                  n.cnt = 5'h00;
               end
            end
         end
      end
      if (rd_acc & (avs_address == addr_of(IDX_SPI_DATA))) n.spi_ctl[B_DONE] = 1'b0;
      if ((rd_acc | wr_acc) & (avs_address == addr_of(IDX_IIC_DATA))) begin
         n.iic_ctl[B_IIC_FLAG] = 1'b0;
      end

      // serial port engine
      if (spi_en & master & (q.spi_st == SPI_RUN)) begin
         n.hcnt = q.hcnt + 8'h01;
         if (q.hcnt == rate_half(q.spi_ctl[B_RATE_HI:B_RATE_LO]) - 8'h01) begin
            n.hcnt = 8'h00;
            n.sclk_o = ~q.sclk_o;
            ev = 1'b1;
            lead = ~q.cnt[0];
         end
      end else if (spi_en & ~master & ~q.f_ss) begin
         ev = n.f_scl != q.f_scl;
         lead = q.f_scl == clock_idle_level;
      end
      if (ev) begin
         sample = lead ^ clock_edge_phase;
         if (sample) begin
            n.sh = {n.sh[6:0], master ? q.f_miso : q.f_sda};
         end else begin
            n.dout = n.sh[7];
         end
         n.cnt = q.cnt + 5'h01;
         // phase 1 ends on eighth clock
         if ((q.cnt == LAST_EDGE) & (master | clock_edge_phase)) fin = 1'b1;
      end
      if (spi_en & ~master) begin
         // phase 0 ends on select rise
         if (ss_rise & ~clock_edge_phase & (q.cnt != 5'h00)) fin = 1'b1;
         if (n.f_ss) n.cnt = 5'h00;
      end
      if (fin) begin
         n.spi_dat = n.sh;
         n.spi_ctl[B_DONE] = 1'b1;
         n.spi_st = SPI_IDLE;
         n.cnt = 5'h00;
      end
      if (n.spi_st != SPI_RUN) n.sclk_o = clock_idle_level;
      if (~spi_en) begin
         n.spi_st = SPI_IDLE;
         n.cnt = 5'h00;
      end

      if (~spi_en & q.iic_ctl[B_IIC_MSEL] & ~q.iic_ctl[B_SW_DEN] & scl_rise) begin
         n.iic_ctl[B_SW_DIN] = q.f_sda;
      end
      // slave runs only in hardware slave mode
      iic_on = ~spi_en & ~q.iic_ctl[B_IIC_MSEL] & ~q.iic_ctl[B_IIC_SRST];
      if (~iic_on) begin
         n.act = 1'b0;
         n.match = 1'b0;
         n.ibit = 4'h0;
         n.ackdrv = 1'b0;
         n.txbit = 1'b1;
         if (q.iic_ctl[B_IIC_SRST]) begin
            n.iic_ctl[B_IIC_FLAG] = 1'b0;
            n.iic_ctl[B_IIC_DIR] = 1'b0;
         end
      end else if (q.f_scl & n.f_scl & sda_fall) begin
         n.act = 1'b1;
         n.match = 1'b0;
         n.ibit = 4'h0;
         n.ackdrv = 1'b0;
         n.txbit = 1'b1;
      end else if (q.f_scl & n.f_scl & sda_rise) begin
         n.act = 1'b0;
         n.match = 1'b0;
         n.ackdrv = 1'b0;
         n.txbit = 1'b1;
      end else if (q.act) begin
         if (scl_rise) begin
            if (q.ibit < IIC_ACK_BIT) begin
               n.ish = {q.ish[6:0], q.f_sda};
               n.ibit = q.ibit + 4'h1;
            end else if (q.match & dir & q.f_sda) begin
               n.act = 1'b0;
               n.match = 1'b0;
            end else begin
               n.ibit = IIC_END_BIT;
            end
         end
         if (scl_fall) begin
            if (q.ibit == IIC_ACK_BIT) begin
               n.txbit = 1'b1;
               if (~q.match) begin
                  if (q.ish[7:1] == q.iic_adr[6:0]) begin
                     n.match = 1'b1;
                     n.iic_ctl[B_IIC_DIR] = q.ish[0];
                     n.iic_dat = q.ish;
                     n.ackdrv = 1'b1;
                  end else begin
                     n.act = 1'b0;
                  end
               end else if (~dir) begin
                  n.iic_dat = q.ish;
                  n.ackdrv = 1'b1;
               end
            end else if (q.ibit == IIC_END_BIT) begin
               n.ackdrv = 1'b0;
               n.ibit = 4'h0;
               n.iic_ctl[B_IIC_FLAG] = q.match;
            end else if (q.ibit < IIC_ACK_BIT) begin
               n.txbit = q.ish[7];
            end
         end
      end

      n.miso_out = 1'b0;
      n.miso_oe = 1'b0;
      if (spi_en) begin
         n.scl_oe = master;
         n.scl_out = n.sclk_o;
         n.sda_oe = master;
         n.sda_out = n.dout;
         n.miso_oe = ~master & ~n.f_ss;
         n.miso_out = n.dout;
      end else if (q.iic_ctl[B_IIC_MSEL]) begin
         n.scl_oe = 1'b1;
         n.scl_out = n.iic_ctl[B_SW_CLK];
         n.sda_oe = n.iic_ctl[B_SW_DEN];
         n.sda_out = n.iic_ctl[B_SW_DOUT];
      end else begin
         n.scl_oe = n.act & n.match & n.iic_ctl[B_IIC_FLAG];
         n.scl_out = 1'b0;
         n.sda_oe = n.act & (n.ackdrv | (n.match & n.iic_ctl[B_IIC_DIR] &
                    (n.ibit < IIC_ACK_BIT) & ~n.txbit));
         n.sda_out = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         q <= '0;
         q.s_ss <= 3'h7;
         q.f_ss <= 1'b1;
         q.waitreq <= 1'b1;
         q.spi_ctl <= RST_SPI_CTL;
         q.spi_dat <= RST_SPI_DATA;
         q.spi_st <= SPI_IDLE;
         q.iic_ctl <= RST_IIC_CTL;
         q.iic_dat <= RST_IIC_DATA;
         q.iic_adr <= RST_IIC_ADDR;
         q.txbit <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign avs_readdata = {24'h000000, q.rdata};
   assign avs_waitrequest = q.waitreq;
   assign shared_serial_clock_out = q.scl_out;
   assign shared_serial_clock_oe = q.scl_oe;
   assign shared_serial_data_out = q.sda_out;
   assign shared_serial_data_oe = q.sda_oe;
   assign miso_out = q.miso_out;
   assign miso_oe = q.miso_oe;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_ss_gate: assert property (q.spi_ctl[B_PINS] & ~q.spi_ctl[B_MASTER] & q.f_ss
      |=> q.cnt == 5'h00) else $error("slave counted while deselected");
   a_ss_read: assert property (req & q.waitreq & (avs_address == addr_of(IDX_SPI_CTL))
      & ~q.spi_ctl[B_MASTER] |=> q.rdata[B_RATE_LO] == $past(q.f_ss))
      else $error("select level not read back");
   a_done_clr: assert property (rd_acc & (avs_address == addr_of(IDX_SPI_DATA)) & ~fin
      |=> ~q.spi_ctl[B_DONE]) else $error("done not cleared by read");
   a_coll_set: assert property (wr_acc & (avs_address == addr_of(IDX_SPI_DATA)) & busy
      |=> q.spi_ctl[B_COLL]) else $error("collision not flagged");
   a_pin_slave: assert property (q.spi_ctl[B_PINS] & ~q.spi_ctl[B_MASTER]
      & $stable(q.spi_ctl[B_PINS:B_MASTER])
      |-> ~q.scl_oe & ~q.sda_oe) else $error("slave drives clock or mosi");
   a_idle_lvl: assert property (q.spi_ctl[B_PINS] & q.spi_ctl[B_MASTER]
      & $stable(q.spi_ctl[B_PINS:B_PHASE])
      & (q.spi_st == SPI_IDLE) |-> q.scl_out == q.spi_ctl[B_IDLE])
      else $error("clock not at idle level");
   a_run_len: assert property ($rose(q.spi_st == SPI_RUN) |-> (q.spi_st == SPI_RUN) [*8])
      else $error("master byte too short");
   a_run_done: assert property ($fell(q.spi_st == SPI_RUN) & q.spi_ctl[B_PINS]
      |-> q.spi_ctl[B_DONE]) else $error("done missing at byte end");
   a_sw_pins: assert property (~q.spi_ctl[B_PINS] & q.iic_ctl[B_IIC_MSEL]
      & $stable(q.iic_ctl[B_IIC_MSEL]) & $stable(q.spi_ctl[B_PINS]) |->
      q.scl_oe & (q.scl_out == q.iic_ctl[B_SW_CLK]) & (q.sda_oe == q.iic_ctl[B_SW_DEN]))
      else $error("software master pins wrong");
   a_srst_hold: assert property (q.iic_ctl[B_IIC_SRST] |=> ~q.act & ~q.iic_ctl[B_IIC_FLAG])
      else $error("slave not held in reset");
   a_stretch: assert property (~q.spi_ctl[B_PINS] & ~q.iic_ctl[B_IIC_MSEL] & q.act
      & q.match & q.iic_ctl[B_IIC_FLAG] |-> q.scl_oe & ~q.scl_out)
      else $error("clock not stretched");
   c_master_byte: cover property ($fell(q.spi_st == SPI_RUN));
   c_slave_byte: cover property (~q.spi_ctl[B_MASTER] & $rose(q.spi_ctl[B_DONE]));
   c_iic_flag: cover property ($rose(q.iic_ctl[B_IIC_FLAG]));
endmodule

/* verification/ssp_far_end.sv */
`timescale 1ns/1ps
module ssp_far_end (
   input wire logic clk_w, // clock wire level
   input wire logic mosi_w, // mosi wire level
   input wire logic miso_w, // miso wire level
   input wire logic clock_idle_level, // idle level
   input wire logic clock_edge_phase, // phase
   input wire logic sel, // act as selected slave
   input wire logic [7:0] tx, // byte to return as slave
   output logic [7:0] rx, // byte captured as slave
   output logic miso_d, // miso drive value
   output logic miso_en, // miso drive enable
   output logic sclk_d, // clock drive value
   output logic sclk_en, // clock drive enable
   output logic mosi_d, // mosi drive value
   output logic mosi_en, // mosi drive enable
   output logic ss_n // select towards the device
);
   logic [7:0] sh;
   int nl;
   initial begin
      {sclk_en, mosi_en, sclk_d, mosi_d, ss_n} = 5'b00001;
      rx = 8'h00;
      sh = 8'h00;
      nl = 0;
   end
   assign miso_en = sel;
   assign miso_d = sh[7];
   always @(posedge sel) begin
      sh = tx;
      nl = 0;
   end
   always @(clk_w) begin
      if (sel) begin
         if ((clk_w != clock_idle_level) ^ clock_edge_phase) rx = {rx[6:0], mosi_w};
         else begin
            if (!clock_edge_phase || nl > 0) sh = {sh[6:0], ~sh[0]};
            nl++;
         end
      end
   end
   // select framed per byte, msb first
   task automatic send(input logic [7:0] b, input logic use_ss, output logic [7:0] got);
      int i;
      sclk_d = clock_idle_level;
      sclk_en = 1'b1;
      mosi_en = 1'b1;
      mosi_d = b[7];
      #80;
      ss_n = ~use_ss;
      #80;
      for (i = 0; i < 8; i++) begin
         sclk_d = ~clock_idle_level;
         if (clock_edge_phase) mosi_d = b[3'(7 - i)];
         else got = {got[6:0], miso_w};
         #80;
         sclk_d = clock_idle_level;
         if (clock_edge_phase) got = {got[6:0], miso_w};
         else mosi_d = (i < 7) ? b[3'(6 - i)] : ~b[0];
         #80;
      end
      ss_n = 1'b1;
      #80;
      sclk_en = 1'b0;
      mosi_en = 1'b0;
   endtask
endmodule

/* verification/tb_shared_spi_iic_serial_port.sv */
`timescale 1ns/1ps
module tb_shared_spi_iic_serial_port;
   import ssp_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic clk_out, clk_oe, dat_out, dat_oe, so_out, so_oe;
   logic p_miso, p_miso_en, p_sclk, p_sclk_en, p_mosi, p_mosi_en, p_ss_n;
   logic clock_idle_level = 1'b0, clock_edge_phase = 1'b0, p_sel = 1'b0, scl_lo = 1'b0, sda_lo = 1'b0;
   logic miso_last = 1'b0, ack;
   logic [7:0] p_tx = 8'h00, p_rx, got, b, c;
   int error_cnt = 0, checks_done = 0, cyc = 0, k;
   // shared lines carry pull-ups, miso does not
   wire clk_w = (clk_oe ? clk_out : 1'b1) & (p_sclk_en ? p_sclk : 1'b1) & ~scl_lo;
   wire mosi_w = (dat_oe ? dat_out : 1'b1) & (p_mosi_en ? p_mosi : 1'b1) & ~sda_lo;
   wire miso_w = so_oe ? so_out : (p_miso_en ? p_miso : ~miso_last);
   always @(miso_w) if (so_oe || p_miso_en) miso_last = miso_w;
   always #10 mclk = ~mclk;
   ssp_top u_dut (.mclk(mclk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .shared_serial_clock_in(clk_w),
      .shared_serial_clock_out(clk_out), .shared_serial_clock_oe(clk_oe),
      .shared_serial_data_in(mosi_w), .shared_serial_data_out(dat_out),
      .shared_serial_data_oe(dat_oe), .miso_in(miso_w), .miso_out(so_out),
      .miso_oe(so_oe), .slave_select_n(p_ss_n));
   ssp_far_end u_far (.clk_w(clk_w), .mosi_w(mosi_w), .miso_w(miso_w), .clock_idle_level(clock_idle_level),
      .clock_edge_phase(clock_edge_phase), .sel(p_sel), .tx(p_tx), .rx(p_rx), .miso_d(p_miso), .miso_en(p_miso_en),
      .sclk_d(p_sclk), .sclk_en(p_sclk_en), .mosi_d(p_mosi), .mosi_en(p_mosi_en),
      .ss_n(p_ss_n));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
         output logic [7:0] q);
      int n;
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h0, wd};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) error_cnt++;
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      check(what, q, e);
   endtask
   task automatic wait_done();
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, IDX_SPI_CTL, 8'h00, q);
         n++;
      end while (q[B_DONE] !== 1'b1 && n < 600);
      if (n >= 600) error_cnt++;
   endtask
   // start, address byte, ninth clock; clock left held low by the bench
   task automatic iic_addr(input logic [7:0] a, output logic ak);
      int i;
      sda_lo = 1'b1;
      #80;
      scl_lo = 1'b1;
      for (i = 0; i < 9; i++) begin
         #40;
         sda_lo = (i < 8) ? ~a[3'(7 - i)] : 1'b0;
         #40;
         scl_lo = 1'b0;
         #80;
         if (i == 8) ak = ~mosi_w;
         scl_lo = 1'b1;
      end
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("ERROR timeout");
         stop_test();
      end
   end
   initial begin
      void'($urandom(5190));
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      rdc("iic_data", IDX_IIC_DATA, 8'h00);
      rdc("iic_own_address", IDX_IIC_ADDR, 8'h55);
      rdc("iic_control", IDX_IIC_CTL, 8'h00);
      rdc("spi_data", IDX_SPI_DATA, 8'h00);
      rdc("spi_control", IDX_SPI_CTL, 8'h01);
      rdc("unmapped", 8'h10, 8'h00);
      c = 8'($urandom) & 8'h7f;
      wr(IDX_IIC_ADDR, c);
      avs_byteenable <= 4'h0;
      wr(IDX_IIC_ADDR, ~c);
      avs_byteenable <= 4'h1;
      rdc("own address", IDX_IIC_ADDR, c);
      for (k = 0; k < 4; k++) begin
         clock_idle_level = k[1];
         clock_edge_phase = k[0];
         wr(IDX_SPI_CTL, {4'h3, clock_idle_level, clock_edge_phase, 2'(k)});
         repeat (3) @(posedge mclk);
         #1 check("clock idle", {6'h0, clk_oe, clk_out}, {7'h1, clock_idle_level});
         p_tx = 8'($urandom);
         b = 8'($urandom);
         p_sel = 1'b1;
         wr(IDX_SPI_DATA, b);
         wr(IDX_SPI_DATA, ~b);
         wait_done();
         p_sel = 1'b0;
         check("far end rx", p_rx, b);
         rdc("done and collision", IDX_SPI_CTL, {4'hf, clock_idle_level, clock_edge_phase, 2'(k)});
         rdc("master spi_data", IDX_SPI_DATA, p_tx);
         rdc("done cleared", IDX_SPI_CTL, {4'h7, clock_idle_level, clock_edge_phase, 2'(k)});
         wr(IDX_SPI_CTL, {4'h3, clock_idle_level, clock_edge_phase, 2'(k)});
         rdc("collision cleared", IDX_SPI_CTL, {4'h3, clock_idle_level, clock_edge_phase, 2'(k)});
      end
      for (k = 0; k < 4; k++) begin
         clock_idle_level = k[1];
         clock_edge_phase = k[0];
         wr(IDX_SPI_CTL, {4'h2, clock_idle_level, clock_edge_phase, 2'b00});
         c = 8'($urandom);
         b = 8'($urandom);
         wr(IDX_SPI_DATA, c);
         #3 u_far.send(~b, 1'b0, got);
         rdc("select high burst", IDX_SPI_CTL, {4'h2, clock_idle_level, clock_edge_phase, 2'b01});
         #3 check("slave clock input", {7'h0, clk_oe}, 8'h00);
         u_far.send(b, 1'b1, got);
         wait_done();
         check("slave miso", got, c);
         rdc("slave spi_data", IDX_SPI_DATA, b);
      end
      wr(IDX_SPI_CTL, 8'h00);
      repeat (4) @(posedge mclk);
      #1 check("pins to two-wire", {6'h0, clk_oe, dat_oe}, 8'h00);
      wr(IDX_IIC_CTL, 8'hff);
      rdc("iic_control write", IDX_IIC_CTL, 8'hec);
      wr(IDX_IIC_CTL, 8'h08);
      repeat (8) @(posedge mclk);
      #1 check("sw master pins", {5'h0, clk_oe, clk_out, dat_oe}, 8'h04);
      wr(IDX_IIC_CTL, 8'h28);
      repeat (8) @(posedge mclk);
      rdc("data in high", IDX_IIC_CTL, 8'h38);
      sda_lo = 1'b1;
      wr(IDX_IIC_CTL, 8'h08);
      repeat (8) @(posedge mclk);
      wr(IDX_IIC_CTL, 8'h28);
      repeat (8) @(posedge mclk);
      rdc("data in low", IDX_IIC_CTL, 8'h28);
      sda_lo = 1'b0;
      wr(IDX_IIC_CTL, 8'hc8);
      repeat (4) @(posedge mclk);
      #1 check("sw master drive", {6'h0, dat_oe, dat_out}, 8'h03);
      wr(IDX_IIC_CTL, 8'h00);
      c = 8'($urandom) & 8'h7f;
      wr(IDX_IIC_ADDR, c);
      #3 iic_addr({c[6:0], 1'b0}, ack);
      check("address ack", {7'h0, ack}, 8'h01);
      sda_lo = 1'b1;
      #200;
      scl_lo = 1'b0;
      #200;
      check("clock stretched", {7'h0, clk_w}, 8'h00);
      rdc("byte flag", IDX_IIC_CTL, 8'h01);
      // one data access per byte event
      rdc("address byte", IDX_IIC_DATA, {c[6:0], 1'b0});
      rdc("flag cleared", IDX_IIC_CTL, 8'h00);
      #200;
      check("clock released", {7'h0, clk_w}, 8'h01);
      sda_lo = 1'b0;
      #200;
      stop_test();
   end
endmodule
